// *** core/fcrb_pkg.sv ***
// constants and types of the flag-clear relative branch unit
package fcrb_pkg;
  localparam int PC_W = 21;
  localparam int INSN_W = 16;
  localparam int OFS_W = 8;
  localparam logic [7:0] OPC_BR_CARRY_CLR = 8'hE3;
  localparam logic [7:0] OPC_BR_NEG_CLR = 8'hE7;
  localparam logic [7:0] OPC_BR_OVF_CLR = 8'hE5;
  localparam logic [7:0] OPC_BR_NEG_SET = 8'hE6;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [1:0] Q_1 = 2'h0;
  localparam logic [1:0] Q_2 = 2'h1;
  localparam logic [1:0] Q_3 = 2'h2;
  localparam logic [1:0] Q_4 = 2'h3;
  localparam int FLAG_C = 0;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  typedef enum logic [2:0] {
    FCRB_EXEC = 3'h1,
    FCRB_FLUSH = 3'h2,
    FCRB_IDLE = 3'h4
  } fcrb_state_e;
endpackage

// *** core/fcrb_cond.sv ***
// condition test for one branch opcode against the status flags
`timescale 1ns/10ps
`default_nettype none
module fcrb_cond
  import fcrb_pkg::*;
(
  input wire logic [7:0] i_opc,
  input wire logic [7:0] i_flags,
  output logic o_is_branch,
  output logic o_take
);
  always_comb begin
    o_is_branch = 1'b1;
    o_take = 1'b0;
    if (i_opc == OPC_BR_CARRY_CLR) begin
      o_take = ~i_flags[FLAG_C];
    end else if (i_opc == OPC_BR_NEG_CLR) begin
      o_take = ~i_flags[FLAG_N];
    end else if (i_opc == OPC_BR_OVF_CLR) begin
      o_take = ~i_flags[FLAG_OV];
    end else if (i_opc == OPC_BR_NEG_SET) begin
      o_take = i_flags[FLAG_N];
    end else begin
      o_is_branch = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** core/fcrb_top.sv ***
// flag-clear relative branch execute unit with q-phase sequencing
`timescale 1ns/10ps
`default_nettype none
module fcrb_top
  import fcrb_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic i_insn_valid,
  input wire logic [INSN_W-1:0] i_insn,
  input wire logic [PC_W-1:0] i_fetch_pc,
  input wire logic [7:0] i_status,
  output logic O_PC_LOAD,
  output logic [PC_W-1:0] O_PC_TARGET,
  output logic O_FLUSH,
  output logic O_BUSY,
  output logic O_DONE,
  output logic [1:0] O_QPHASE
);
  // ----------------------------------------
  // phase counter
  // ----------------------------------------
  logic [1:0] q_r;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      q_r <= Q_1;
    end else begin
      q_r <= q_r + 2'h1;
    end
  end

  // ----------------------------------------
  // decode and latch in q1
  // ----------------------------------------
  fcrb_state_e state_r;
  fcrb_state_e state_nxt;
  logic [OFS_W-1:0] ofs_r;
  logic [PC_W-1:0] base_r;
  logic [7:0] opc_r;
  logic [7:0] flags_r;
  logic is_br;
  logic take;
  logic [PC_W-1:0] tgt_r;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      opc_r <= 8'h00;
      base_r <= PC_RST;
    end else if (q_r == Q_1 && state_r != FCRB_FLUSH) begin
      // empty slot clears the opcode so a stale branch never runs again
      opc_r <= i_insn_valid ? i_insn[INSN_W-1:OFS_W] : 8'h00;
      base_r <= i_fetch_pc;
    end
  end

  // offset literal read in q2
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ofs_r <= 8'h00;
    end else if (q_r == Q_2) begin
      ofs_r <= i_insn[OFS_W-1:0];
    end
  end

  // flags sampled as read, never written
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      flags_r <= 8'h00;
    end else if (q_r == Q_3) begin
      flags_r <= i_status;
    end
  end

  fcrb_cond u_cond (
    .i_opc(opc_r),
    .i_flags(flags_r),
    .o_is_branch(is_br),
    .o_take(take)
  );

  // process data in q3: sign extend, double, add
  logic [PC_W-1:0] ofs2;
  assign ofs2 = {{(PC_W-OFS_W-1){ofs_r[OFS_W-1]}}, ofs_r, 1'b0};
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      tgt_r <= PC_RST;
    end else if (q_r == Q_3) begin
      tgt_r <= base_r + ofs2;
    end
  end

  // ----------------------------------------
  // cycle state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FCRB_IDLE: begin
        if (q_r == Q_4 && i_insn_valid) begin
          state_nxt = FCRB_EXEC;
        end
      end
      FCRB_EXEC: begin
        if (q_r == Q_4) begin
          state_nxt = (is_br && take) ? FCRB_FLUSH : FCRB_EXEC;
        end
      end
      FCRB_FLUSH: begin
        if (q_r == Q_4) begin
          state_nxt = FCRB_EXEC;
        end
      end
      default: state_nxt = FCRB_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state_r <= FCRB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic wr_pc;
  assign wr_pc = state_r == FCRB_EXEC && q_r == Q_4 && is_br && take;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_PC_LOAD <= 1'b0;
      O_PC_TARGET <= PC_RST;
      O_FLUSH <= 1'b0;
      O_DONE <= 1'b0;
    end else begin
      O_PC_LOAD <= wr_pc;
      O_PC_TARGET <= wr_pc ? tgt_r : O_PC_TARGET;
      O_FLUSH <= wr_pc;
      O_DONE <= q_r == Q_4 && is_br &&
                ((state_r == FCRB_EXEC && !take) || state_r == FCRB_FLUSH);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_BUSY <= 1'b0;
      O_QPHASE <= Q_1;
    end else begin
      O_BUSY <= state_nxt == FCRB_FLUSH;
      O_QPHASE <= q_r + 2'h1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_load_q4: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_PC_LOAD |-> $past(q_r) == Q_4)
    else $error("pc load outside q4");
  chk_load_cond: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_PC_LOAD |-> $past(is_br && take))
    else $error("pc load without condition");
  chk_flush_pair: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_FLUSH == O_PC_LOAD)
    else $error("flush not paired with load");
  chk_busy_span: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(O_BUSY) |-> O_BUSY [*4] ##1 !O_BUSY)
    else $error("flush cycle length wrong");
  chk_no_back_load: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_PC_LOAD |=> !O_PC_LOAD [*4])
    else $error("load during flush");
  chk_neg_set: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (opc_r == OPC_BR_NEG_SET) |-> take == flags_r[FLAG_N])
    else $error("negative set test wrong");
  chk_neg_clr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (opc_r == OPC_BR_NEG_CLR) |-> take != flags_r[FLAG_N])
    else $error("negative clear test wrong");
  chk_ovf_clr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (opc_r == OPC_BR_OVF_CLR) |-> take != flags_r[FLAG_OV])
    else $error("overflow clear test wrong");
  chk_target: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_PC_LOAD |-> O_PC_TARGET == $past(base_r) + $past(ofs2))
    else $error("target address wrong");
  chk_flags_q3: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $past(q_r) == Q_3 |-> flags_r == $past(i_status))
    else $error("flags not sampled");
  chk_carry_clr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (opc_r == OPC_BR_CARRY_CLR) |-> take != flags_r[FLAG_C])
    else $error("carry clear test wrong");
  chk_ofs_sign: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ofs2[PC_W-1] == ofs_r[OFS_W-1] && ofs2[OFS_W:1] == ofs_r && ofs2[0] == 1'b0)
    else $error("offset extension wrong");
  chk_no_stale: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ($past(q_r) == Q_1 && !$past(i_insn_valid) && $past(state_r) != FCRB_FLUSH) |-> !is_br)
    else $error("stale opcode kept");
  chk_done_pulse: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_DONE |=> !O_DONE)
    else $error("done longer than one clock");
  chk_idle_quiet: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (state_r == FCRB_IDLE) |=> !O_PC_LOAD)
    else $error("load while idle");

  cov_taken: cover property (@(posedge I_CLK) O_PC_LOAD);
  cov_not_taken: cover property (@(posedge I_CLK) O_DONE && !O_BUSY);
  cov_neg_set: cover property (@(posedge I_CLK) O_PC_LOAD && opc_r == OPC_BR_NEG_SET);
  cov_back: cover property (@(posedge I_CLK) O_PC_LOAD && ofs_r[OFS_W-1]);
endmodule
`default_nettype wire

// *** sim/fcrb_top_tb.sv ***
// self-checking bench for the flag-clear relative branch unit
`timescale 1ns/10ps
`default_nettype none
module fcrb_top_tb;
  import fcrb_pkg::*;
  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] ofs;
    logic [PC_W-1:0] pc;
    logic [7:0] st;
    logic take;
    logic br;
    logic hold;
  } fcrb_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic [INSN_W-1:0] insn = 16'h0000;
  logic [PC_W-1:0] fpc = 21'h000000;
  logic [7:0] st = 8'h00;
  logic ld, fl, busy, done;
  logic [PC_W-1:0] tgt;
  logic [1:0] ph;
  int err_count = 0;
  int checks = 0;
  fcrb_row_s rows [12] = '{
    '{8'hE3, 8'h7F, 21'h001000, 8'h00, 1'b1, 1'b1, 1'b0},
    '{8'hE3, 8'h7F, 21'h001000, 8'h01, 1'b0, 1'b1, 1'b0},
    '{8'hE7, 8'h80, 21'h001000, 8'h00, 1'b1, 1'b1, 1'b0},
    '{8'hE7, 8'h80, 21'h001000, 8'h10, 1'b0, 1'b1, 1'b0},
    '{8'hE5, 8'hFF, 21'h001000, 8'h00, 1'b1, 1'b1, 1'b0},
    '{8'hE5, 8'hFF, 21'h001000, 8'h08, 1'b0, 1'b1, 1'b0},
    '{8'hE6, 8'h01, 21'h001000, 8'h10, 1'b1, 1'b1, 1'b0},
    '{8'hE6, 8'h01, 21'h001000, 8'h00, 1'b0, 1'b1, 1'b0},
    '{8'hE3, 8'h05, 21'h001000, 8'hFE, 1'b1, 1'b1, 1'b0},
    '{8'hE2, 8'h05, 21'h001000, 8'h01, 1'b0, 1'b0, 1'b0},
    '{8'hE3, 8'h80, 21'h000010, 8'h00, 1'b1, 1'b1, 1'b0},
    '{8'hE7, 8'h02, 21'h0ABCDE, 8'h00, 1'b1, 1'b1, 1'b1}
  };
  always #20 clk = ~clk;
  fcrb_top fcrb_top_inst (.I_CLK(clk), .I_SYS_RST(rst), .i_insn_valid(vld), .i_insn(insn),
    .i_fetch_pc(fpc), .i_status(st), .O_PC_LOAD(ld), .O_PC_TARGET(tgt), .O_FLUSH(fl),
    .O_BUSY(busy), .O_DONE(done), .O_QPHASE(ph));
  task automatic cmp_val(input string n, input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic cmp_cnt(input string n, input int e, input int g);
    cmp_val(n, e[PC_W-1:0], g[PC_W-1:0]);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one instruction from the q1 boundary, twelve clocks observed
  task automatic run_row(input fcrb_row_s r);
    int nl, nd, nb, la, da, bad;
    logic [PC_W-1:0] got;
    nl = 0; nd = 0; nb = 0; la = 0; da = 0; bad = 0; got = '0;
    do begin
      @(posedge clk);
      #1;
    end while (ph !== Q_4);
    @(posedge clk);
    vld <= 1'b1;
    insn <= {r.opc, r.ofs};
    fpc <= r.pc;
    st <= r.st;
    for (int i = 1; i <= 12; i++) begin
      @(posedge clk);
      if (i == (r.hold ? 8 : 4)) vld <= 1'b0;
      #1;
      if (ld === 1'b1) begin
        nl++; la = i; got = tgt;
      end
      if (done === 1'b1) begin
        nd++; da = i;
      end
      if (busy === 1'b1) nb++;
      if (fl !== ld || ph !== 2'(i % 4)) bad++;
    end
    cmp_cnt("loads", int'(r.take), nl);
    cmp_cnt("dones", int'(r.br), nd);
    cmp_cnt("flush_phase", 0, bad);
    cmp_cnt("busy", r.take ? 4 : 0, nb);
    if (r.br) cmp_cnt("done_at", r.take ? 8 : 4, da);
    if (r.take) begin
      cmp_val("target", r.pc + {{(PC_W-9){r.ofs[7]}}, r.ofs, 1'b0}, got);
      cmp_cnt("load_at", 4, la);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    vld <= 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // reset in the middle of a taken branch
    @(posedge clk);
    vld <= 1'b1;
    insn <= 16'hE310;
    repeat (6) @(posedge clk);
    rst <= 1'b1;
    vld <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp_val("reset_outs", '0, PC_W'({ld, fl, busy, done, ph}));
    cmp_val("reset_tgt", PC_RST, tgt);
    @(posedge clk);
    rst <= 1'b0;
    vld <= 1'b1;
    insn <= 16'h0000;
    run_row(rows[0]);
    $display("reset test done");
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
